// File: rtl/sincf_pkg.sv
// constants for the third-order sinc decimation filter
// Functional notes
// - each output reflects the weighted sum over the latest order times ratio input bits.
// - first-order sum equals previous sum plus newest bit minus bit ratio ago.
// - integrators come before combs and accumulate input every sample clock.
// - last integrator is captured once every ratio samples; combs run at that rate.
// - each comb outputs current minus previous decimated input, one delay register.
// - first-order reduced section uses one accumulator and one comb delay register.
// - all integrators chained first, decimate at last one, then equal combs.
// - oversampling ratio fixed at 120 samples per output word.
// - order fixed at three: three integrators, decimator, three combs.
// - each result is a 16-bit word.
// - modulator sample clock between 0.5 and 6 MHz, output at most 50 kHz.
// - offset calibration stores result with shorted inputs, later subtracted from results.
// - output invalid until order times ratio bits entered, then valid every ratio; the code gives no valid word while calib_en is set.
package sincf_pkg;
   localparam int OVERSAMPLING_RATIO = 120;
   localparam int FILTER_ORDER = 3;
   localparam int OUT_WIDTH = 16;
   // 120^3 = 1728000 needs 21 bits
   localparam int ACC_WIDTH = 21;
   localparam int CNT_WIDTH = 7;
   localparam int FILL_WIDTH = 2;
   localparam logic [CNT_WIDTH-1:0] RATIO_LAST = 7'h77;
   localparam logic [FILL_WIDTH-1:0] FILL_DONE = 2'h2;
   localparam logic [OUT_WIDTH-1:0] OFFSET_RESET = 16'h0000;
   localparam int SAMPLE_CLK_MIN_KHZ = 500;
   localparam int SAMPLE_CLK_MAX_KHZ = 6000;
   localparam int OUT_RATE_MAX_KHZ = 50;
endpackage : sincf_pkg

// File: rtl/sincf_comb.sv
// one comb differentiator stage at the decimated rate
`timescale 1ns/1ps
`default_nettype none
module sincf_comb #(
   parameter int WIDTH = 21
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic dec_stb,
   input wire logic [WIDTH-1:0] din,
   output var logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] delay_reg;
   logic [WIDTH-1:0] delay_next;
   logic [WIDTH-1:0] dout_next;

   always_comb
   begin
      delay_next = delay_reg;
      dout_next = dout;
      if (dec_stb)
      begin
         delay_next = din;
         dout_next = din - delay_reg;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         delay_reg <= '0;
         dout <= '0;
      end
      else
      begin
         delay_reg <= delay_next;
         dout <= dout_next;
      end
   end
endmodule : sincf_comb
`default_nettype wire

// File: rtl/sincf_filter.sv
// third-order sinc decimation filter, bitstream to 16-bit words
`timescale 1ns/1ps
`default_nettype none
module sincf_filter
   import sincf_pkg::*;
#(
   parameter int RATIO = sincf_pkg::OVERSAMPLING_RATIO,
   parameter int ORDER = sincf_pkg::FILTER_ORDER
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sample_stb,
   input wire logic bit_in,
   input wire logic calib_en,
   output var logic [sincf_pkg::OUT_WIDTH-1:0] result,
   output var logic result_valid,
   output var logic [sincf_pkg::OUT_WIDTH-1:0] offset_value
);
   import sincf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // the datapath is sized for the fixed ratio and order only
   if (RATIO != OVERSAMPLING_RATIO || ORDER != FILTER_ORDER)
   begin : g_bad_param
      $error("sincf_filter supports only ratio 120 and order 3");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // input synchronisers: the modulator is outside this clock domain
   logic stb_s1_reg;
   logic stb_s2_reg;
   logic stb_s3_reg;
   logic bit_s1_reg;
   logic bit_s2_reg;
   logic bit_s3_reg;
   logic cal_s1_reg;
   logic cal_s2_reg;
   logic sample_tick;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         stb_s1_reg <= 1'b0;
         stb_s2_reg <= 1'b0;
         stb_s3_reg <= 1'b0;
         bit_s1_reg <= 1'b0;
         bit_s2_reg <= 1'b0;
         bit_s3_reg <= 1'b0;
         cal_s1_reg <= 1'b0;
         cal_s2_reg <= 1'b0;
      end
      else
      begin
         stb_s1_reg <= sample_stb;
         stb_s2_reg <= stb_s1_reg;
         stb_s3_reg <= stb_s2_reg;
         bit_s1_reg <= bit_in;
         bit_s2_reg <= bit_s1_reg;
         bit_s3_reg <= bit_s2_reg;
         cal_s1_reg <= calib_en;
         cal_s2_reg <= cal_s1_reg;
      end
   end

   // rising edge of the modulator clock; bit delayed to match
   // modulator clock must stay below core_clk/4 (0.5..6 MHz holds)
   assign sample_tick = stb_s2_reg & ~stb_s3_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // integrator chain, ratio counter and fill tracking
   logic [ACC_WIDTH-1:0] integ_reg [FILTER_ORDER];
   logic [ACC_WIDTH-1:0] integ_next [FILTER_ORDER];
   logic [ACC_WIDTH-1:0] integ_in [FILTER_ORDER];
   logic [CNT_WIDTH-1:0] cnt_reg;
   logic [CNT_WIDTH-1:0] cnt_next;
   logic [FILL_WIDTH-1:0] fill_reg;
   logic [FILL_WIDTH-1:0] fill_next;
   logic dec_stb_reg;
   logic dec_stb_next;
   logic [ACC_WIDTH-1:0] dec_sample_reg;
   logic [ACC_WIDTH-1:0] dec_sample_next;
   logic primed_reg;
   logic primed_next;

   assign integ_in[0] = {{(ACC_WIDTH-1){1'b0}}, bit_s3_reg};

   for (genvar i = 0; i < FILTER_ORDER; i++)
   begin : g_integ
      if (i > 0)
      begin : g_link
         assign integ_in[i] = integ_next[i-1]; // newest sum, no lag between stages
      end
      // running sum, overflow wraps and cancels in the combs
      assign integ_next[i] = sample_tick ? integ_reg[i] + integ_in[i] : integ_reg[i];
      always_ff @(posedge core_clk or posedge rst)
      begin
         if (rst)
            integ_reg[i] <= '0;
         else
            integ_reg[i] <= integ_next[i];
      end
   end

   always_comb
   begin
      cnt_next = cnt_reg;
      fill_next = fill_reg;
      dec_stb_next = 1'b0;
      dec_sample_next = dec_sample_reg;
      primed_next = primed_reg;
      if (sample_tick)
      begin
         if (cnt_reg == RATIO_LAST)
         begin
            cnt_next = '0;
            dec_stb_next = 1'b1;
            // take the last integrator once per ratio samples
            dec_sample_next = integ_next[FILTER_ORDER-1];
            if (fill_reg == FILL_DONE)
               primed_next = 1'b1;
            else
               fill_next = fill_reg + 2'h1;
         end
         else
            cnt_next = cnt_reg + 7'h01;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_reg <= '0;
         fill_reg <= '0;
         dec_stb_reg <= 1'b0;
         dec_sample_reg <= '0;
         primed_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         fill_reg <= fill_next;
         dec_stb_reg <= dec_stb_next;
         dec_sample_reg <= dec_sample_next;
         primed_reg <= primed_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // comb chain at the decimated rate; combined result is the windowed sum
   logic [ACC_WIDTH-1:0] comb_io [FILTER_ORDER+1];
   logic [FILTER_ORDER:0] comb_stb;
   logic [FILTER_ORDER-1:0] stb_pipe_reg;

   assign comb_io[0] = dec_sample_reg;
   // the strobe walks one comb stage per cycle, in step with the data
   assign comb_stb = {stb_pipe_reg, dec_stb_reg};

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         stb_pipe_reg <= '0;
      else
         stb_pipe_reg <= comb_stb[FILTER_ORDER-1:0];
   end

   for (genvar j = 0; j < FILTER_ORDER; j++)
   begin : g_comb
      sincf_comb #(
         .WIDTH(ACC_WIDTH)
      ) u_comb (
         .core_clk(core_clk),
         .rst(rst),
         .dec_stb(comb_stb[j]),
         .din(comb_io[j]),
         .dout(comb_io[j+1])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // scaling, offset correction, output
   // full scale 1728000 does not fit 16 bits; dropping five low bits gives 54000 at most
   logic [OUT_WIDTH-1:0] raw_word;
   logic [OUT_WIDTH-1:0] result_next;
   logic result_valid_next;
   logic [OUT_WIDTH-1:0] offset_next;

   // no saturation needed, so the top code never clips
   assign raw_word = comb_io[FILTER_ORDER][ACC_WIDTH-1:ACC_WIDTH-OUT_WIDTH];

   always_comb
   begin
      result_next = result;
      result_valid_next = 1'b0;
      offset_next = offset_value;
      if (comb_stb[FILTER_ORDER] && primed_reg)
      begin
         if (cal_s2_reg)
            offset_next = raw_word;
         else
         begin
            result_next = raw_word - offset_value;
            result_valid_next = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         result <= '0;
         result_valid <= 1'b0;
         offset_value <= OFFSET_RESET;
      end
      else
      begin
         result <= result_next;
         result_valid <= result_valid_next;
         offset_value <= offset_next;
      end
   end
endmodule : sincf_filter
`default_nettype wire

// File: test/sincf_mod_model.sv
// modulator stand-in: sample strobe and bitstream
`timescale 1ns/1ps
`default_nettype none
module sincf_mod_model (
   input wire logic core_clk,
   input wire logic run,
   input wire logic [8:0] density,
   input wire logic [7:0] half,
   output logic sample_stb,
   output logic bit_in
);
   int seed = 32'h47ccd996;
   initial
   begin
      sample_stb = 1'b0;
      bit_in = 1'b0;
      forever
      begin
         @(posedge core_clk);
         if (run)
         begin
            #1 sample_stb = 1'b1;
            repeat (half) @(posedge core_clk); // half 11 to 125 keeps 0.5..6 MHz
            #1 sample_stb = 1'b0;
            // new bit only after the high phase, so it is stable at the rise
            bit_in = ($unsigned($random(seed)) % 256) < density;
            repeat (half - 1) @(posedge core_clk);
         end
      end
   end
endmodule : sincf_mod_model
`default_nettype wire

// File: test/sincf_chk.sv
// port checker for the sinc3 filter
`timescale 1ns/1ps
`default_nettype none
module sincf_chk
   import sincf_pkg::*;
#(
   parameter int RATIO = 120,
   parameter int ORDER = 3
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sample_stb,
   input wire logic bit_in,
   input wire logic calib_en,
   input wire logic [sincf_pkg::OUT_WIDTH-1:0] result,
   input wire logic result_valid,
   input wire logic [sincf_pkg::OUT_WIDTH-1:0] offset_value
);
   logic [2:0] sync_reg;
   logic [7:0] cnt_reg;
   logic [1:0] blk_reg;
   logic tick;
   logic dtick;
   // same three-stage edge detect as the design, so the word lands exactly 5 edges on
   assign tick = sync_reg[1] & ~sync_reg[2];
   assign dtick = tick && (cnt_reg == 8'(RATIO - 1));
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
      begin
         sync_reg <= 3'h0;
         cnt_reg <= 8'h00;
         blk_reg <= 2'h0;
      end
      else
      begin
         sync_reg <= {sync_reg[1:0], sample_stb};
         if (tick)
            cnt_reg <= dtick ? 8'h00 : cnt_reg + 8'h01;
         if (dtick && blk_reg != 2'(ORDER))
            blk_reg <= blk_reg + 2'h1;
      end
   ////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_dec; dtick && blk_reg >= 2'(ORDER - 1) && !calib_en; endsequence
   sequence s_after_dec; $past(dtick, 5); endsequence
   property p_dec; s_dec |-> ##5 result_valid; endproperty
   property p_cause; result_valid |-> s_after_dec; endproperty
   property p_pulse; result_valid |=> !result_valid; endproperty
   property p_primed; result_valid |-> blk_reg == 2'(ORDER); endproperty
   property p_hold; !result_valid |-> $stable(result); endproperty
   property p_calq; calib_en [*8] |-> !result_valid; endproperty
   property p_offh; !calib_en [*8] |-> $stable(offset_value); endproperty
   property p_offc; !$stable(offset_value) |-> calib_en ##0 s_after_dec; endproperty
   a_dec: assert property (p_dec) else $error("no word after decimation");
   a_cause: assert property (p_cause) else $error("word off the block");
   a_pulse: assert property (p_pulse) else $error("valid too long");
   a_primed: assert property (p_primed) else $error("word before fill");
   a_hold: assert property (p_hold) else $error("word changed alone");
   a_calq: assert property (p_calq) else $error("word in calibration");
   a_offh: assert property (p_offh) else $error("offset moved");
   a_offc: assert property (p_offc) else $error("offset off block");
endmodule : sincf_chk
bind sincf_filter sincf_chk #(.RATIO(RATIO), .ORDER(ORDER)) chk_u (.core_clk(core_clk),
   .rst(rst), .sample_stb(sample_stb), .bit_in(bit_in), .calib_en(calib_en),
   .result(result), .result_valid(result_valid), .offset_value(offset_value));
`default_nettype wire

// File: test/sincf_filter_tb_top.sv
// bench for the sinc3 filter with reference model
`timescale 1ns/1ps
`default_nettype none
module sincf_filter_tb_top;
   import sincf_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic calib_en = 1'b0;
   logic run = 1'b0;
   logic [8:0] density = 9'h000;
   logic [7:0] half = 8'h0B;
   logic sample_stb, bit_in, result_valid;
   logic [OUT_WIDTH-1:0] result, offset_value, exp_off;
   logic [OUT_WIDTH-1:0] expq[$];
   logic [8:0] dens[5] = '{9'h000, 9'h100, 9'h080, 9'h01A, 9'h0E6};
   int n_errors = 0;
   int total_checks = 0;
   int i1, i2, i3, d1, d2, d3, c1, c2, c3, nsmp;
   sincf_mod_model mod_u (.core_clk(core_clk), .run(run), .density(density), .half(half),
      .sample_stb(sample_stb), .bit_in(bit_in));
   sincf_filter dut_u (.core_clk(core_clk), .rst(rst), .sample_stb(sample_stb),
      .bit_in(bit_in), .calib_en(calib_en), .result(result), .result_valid(result_valid),
      .offset_value(offset_value));
   initial
      forever #4 core_clk = ~core_clk;
   ////////////////
   task automatic check(input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("unexpected %0t exp %h got %h", $time, e, g);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task automatic run_samples(input int n);
      int t;
      t = nsmp + n;
      for (int k = 0; k < 100000 && nsmp < t; k++)
         @(posedge core_clk);
      if (nsmp < t)
      begin
         n_errors++;
         give_verdict();
      end
      #1;
   endtask : run_samples
   task automatic reset_dut();
      run = 1'b0;
      if (!rst)
         repeat (100) @(posedge core_clk);
      check(16'h0000, 16'(expq.size()));
      #1 rst = 1'b1;
      {i1, i2, i3, d1, d2, d3, nsmp} = '0;
      exp_off = OFFSET_RESET;
      expq.delete();
      repeat (8) @(posedge core_clk);
      check(16'h0000, result);
      check(16'h0000, {15'h0000, result_valid});
      check(OFFSET_RESET, offset_value);
      #1 rst = 1'b0;
      run = 1'b1;
   endtask : reset_dut
   ////////////////
   // int sums wrap like the hardware; only differences are used
   always @(posedge sample_stb)
   begin
      i1 += bit_in;
      i2 += i1;
      i3 += i2;
      nsmp++;
      if (nsmp % OVERSAMPLING_RATIO == 0)
      begin
         c1 = i3 - d1;
         d1 = i3;
         c2 = c1 - d2;
         d2 = c1;
         c3 = c2 - d3;
         d3 = c2;
         if (nsmp >= FILTER_ORDER * OVERSAMPLING_RATIO && calib_en)
            exp_off = 16'(c3 >> 5);
         else if (nsmp >= FILTER_ORDER * OVERSAMPLING_RATIO)
            expq.push_back(16'(c3 >> 5) - exp_off);
      end
   end
   always @(posedge core_clk)
      if (result_valid === 1'b1)
      begin
         check(expq.size() > 0 ? expq.pop_front() : ~result, result);
         check(exp_off, offset_value);
      end
   initial
   begin
      reset_dut();
      run_samples(60);
      foreach (dens[k])
      begin
         density = dens[k];
         run_samples(360);
      end
      calib_en = 1'b1;
      run_samples(240);
      check(exp_off, offset_value);
      calib_en = 1'b0;
      half = 8'h28;
      run_samples(240);
      half = 8'h0B;
      density = 9'h100;
      reset_dut();
      run_samples(420);
      repeat (20) @(posedge core_clk);
      check(16'h0000, 16'(expq.size()));
      give_verdict();
   end
endmodule : sincf_filter_tb_top
`default_nettype wire
